// >>> wrw_cfg.svh
// How it works
// - The count decrements once every 12,288 CPU clock cycles.
// - While active, rollover from 40h to 3Fh starts a reset pulse of about 500ns.
// - Timeout is programmable in 64 steps of the prescaled period.
// - Activation is cleared by reset, set by software, never cleared by software.
// - A write setting activation with the top count bit clear causes a reset.
// - HALT while active causes an immediate reset instead of halting.
// - The hardware watchdog option keeps the watchdog active regardless of activation.
// - Wait mode does not affect counting or reset generation.
// - Control register resets to 7Fh: activation in bit 7, count in bits 6..0.
// - Status bit 0 records a watchdog reset; cleared by software or power reset.
// - The status register exists only in variants with low voltage detect reset.
`ifndef WRW_CFG_SVH
`define WRW_CFG_SVH

// Register indices; the byte address is four times the index.
`define WRW_CTRL_IDX 8'h2a
`define WRW_STAT_IDX 8'h2b
`define WRW_IRQ_STAT_IDX 8'h2c
`define WRW_IRQ_MASK_IDX 8'h2d

// Control register fields and reset value.
`define WRW_CTRL_ACT_BIT 7
`define WRW_CTRL_TOP_BIT 6
`define WRW_CTRL_RESET 8'h7f
`define WRW_COUNT_ROLL 7'h40

// Status register field and reset value.
`define WRW_STAT_FLAG_BIT 0
`define WRW_STAT_RESET 8'h00

// Interrupt event bits, shared by the sticky status and the mask.
`define WRW_EV_TIMEOUT 0
`define WRW_EV_SOFT 1
`define WRW_EV_HALT 2
`define WRW_EV_WIDTH 3
`define WRW_IRQ_RESET 3'h0

// Timing.
`define WRW_PRESCALE_CYCLES 12288
`define WRW_CLK_PERIOD_NS 20
`define WRW_RESET_PULSE_NS 500
`define WRW_RESET_PULSE_CYCLES ((`WRW_RESET_PULSE_NS + `WRW_CLK_PERIOD_NS - 1) / `WRW_CLK_PERIOD_NS)

`endif

// >>> wrw_pkg.sv
package wrw_pkg;

  // Phase of the reset generator.
  typedef enum logic [0:0] {
    WRW_RUN,
    WRW_PULSE
  } wrw_phase_t;

  // Register selected by an APB address.
  typedef enum logic [2:0] {
    WRW_SEL_CTRL,
    WRW_SEL_STAT,
    WRW_SEL_ISTAT,
    WRW_SEL_IMASK,
    WRW_SEL_NONE
  } wrw_sel_t;

  // Complete state of the watchdog core.
  typedef struct packed {
    wrw_phase_t phase;
    logic [7:0] pulse_cnt;
    logic activate;
    logic [6:0] count;
    logic reset_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic hw_opt;
    logic strap_done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic rst_n;
    logic halt_grant;
  } wrw_state_t;

endpackage : wrw_pkg

// >>> wrw_prescaler.sv
`timescale 1ns/100ps
`include "wrw_cfg.svh"

module wrw_prescaler #(
  parameter int unsigned DIV = `WRW_PRESCALE_CYCLES
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic restart, // Restart the phase from zero.
  output logic tick // One-cycle pulse every DIV cycles.
);

  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } wrw_pre_state_t;

  wrw_pre_state_t st;
  wrw_pre_state_t next_st;

  // Count cycles; a restart drops the partial period so a fresh one begins.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.cnt = '0;
    end else if (st.cnt == CW'(DIV - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = CW'(st.cnt + 1'b1);
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : wrw_prescaler

// >>> wrw_watchdog.sv
`timescale 1ns/100ps
`include "wrw_cfg.svh"

module wrw_watchdog #(
  parameter int unsigned AW = 12,
  parameter int unsigned PRESCALE = `WRW_PRESCALE_CYCLES,
  parameter bit HAS_LVD = 1'b1
) (
  input wire logic pclk, // APB clock, also the CPU clock.
  input wire logic presetn, // Power on/off reset, asynchronous, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [AW-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write byte strobes.
  output logic pready, // APB ready.
  output logic [31:0] prdata, // APB read data.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic mcu_reset_n, // Other system reset sources, synchronous, active low.
  input wire logic hw_watchdog_option, // Hardware watchdog strap, sampled after reset.
  input wire logic halt_exec, // Pulse when the CPU executes HALT.
  output logic halt_grant, // Pulse allowing the CPU to enter halt.
  output logic wdg_reset_n, // Reset request to the MCU, active low.
  output logic irq // Level interrupt from unmasked sticky events.
);

  localparam logic [7:0] PULSE_LAST = 8'(`WRW_RESET_PULSE_CYCLES - 1);

  wrw_pkg::wrw_state_t st;
  wrw_pkg::wrw_state_t next_st;
  logic pre_tick;
  logic pre_restart;

  // Decode a byte address into a register selection.
  function automatic wrw_pkg::wrw_sel_t decode(input logic [AW-1:0] addr);
    logic [AW-3:0] word;
    word = addr[AW-1:2];
    if (addr[1:0] != 2'h0) begin
      decode = wrw_pkg::WRW_SEL_NONE;
    end else if (word == (AW-2)'(`WRW_CTRL_IDX)) begin
      decode = wrw_pkg::WRW_SEL_CTRL;
    end else if (word == (AW-2)'(`WRW_STAT_IDX)) begin
      decode = wrw_pkg::WRW_SEL_STAT;
    end else if (word == (AW-2)'(`WRW_IRQ_STAT_IDX)) begin
      decode = wrw_pkg::WRW_SEL_ISTAT;
    end else if (word == (AW-2)'(`WRW_IRQ_MASK_IDX)) begin
      decode = wrw_pkg::WRW_SEL_IMASK;
    end else begin
      decode = wrw_pkg::WRW_SEL_NONE;
    end
  endfunction : decode

  // Prescaler producing one enable per decrement period.
  wrw_prescaler #(
    .DIV(PRESCALE)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .restart(pre_restart),
    .tick(pre_tick)
  );

  // Combinational helpers for the current cycle.
  wrw_pkg::wrw_sel_t sel;
  logic setup_done;
  logic complete;
  logic wr_ctrl;
  logic active;
  logic timeout_ev;
  logic soft_ev;
  logic halt_ev;
  logic any_ev;
  logic pulse_end;

  // Bus phase decode: the answer is prepared one cycle into the access phase.
  always_comb begin
    sel = decode(paddr);
    setup_done = psel && penable && !st.pready;
    complete = psel && penable && st.pready;
    wr_ctrl = complete && pwrite && pstrb[0] && (sel == wrw_pkg::WRW_SEL_CTRL) && (st.phase == wrw_pkg::WRW_RUN);
  end

  // Reset causes. The hardware option forces the watchdog on.
  always_comb begin
    active = st.activate || st.hw_opt;
    // Counting ignores every low-power mode other than halt.
    timeout_ev = active && pre_tick && (st.count == `WRW_COUNT_ROLL);
    // The written value decides; an activation written in the same access counts.
    soft_ev = wr_ctrl && (active || pwdata[`WRW_CTRL_ACT_BIT]) && !pwdata[`WRW_CTRL_TOP_BIT];
    halt_ev = halt_exec && active && (st.phase == wrw_pkg::WRW_RUN);
    any_ev = (st.phase == wrw_pkg::WRW_RUN) && mcu_reset_n && (timeout_ev || soft_ev || halt_ev);
    pulse_end = (st.phase == wrw_pkg::WRW_PULSE) && (st.pulse_cnt == PULSE_LAST);
  end

  // The prescaler restarts on a load of the count or on any reset of the core.
  assign pre_restart = wr_ctrl || pulse_end || !mcu_reset_n;

  // Next state of the whole core.
  always_comb begin
    logic [2:0] ev_bits;
    logic [7:0] rd_byte;
    next_st = st;
    ev_bits = 3'h0;
    rd_byte = 8'h00;
    next_st.halt_grant = 1'b0;

    // Catch the hardware watchdog strap once, just after power reset is released.
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.hw_opt = hw_watchdog_option;
    end

    // Count down once per prescaled period; 00h wraps to 7Fh.
    if (pre_tick && (st.phase == wrw_pkg::WRW_RUN)) begin
      next_st.count = 7'(st.count - 1'b1);
    end

    // Halt is only granted while the watchdog is inactive.
    if (halt_exec && !active && (st.phase == wrw_pkg::WRW_RUN)) begin
      next_st.halt_grant = 1'b1;
    end

    // Control writes load the count and can only ever set activation.
    if (wr_ctrl) begin
      next_st.count = pwdata[`WRW_CTRL_TOP_BIT:0];
      next_st.activate = st.activate || pwdata[`WRW_CTRL_ACT_BIT];
    end

    // Reset generator sequence.
    case (st.phase)
      wrw_pkg::WRW_RUN: begin
        if (any_ev) begin
          next_st.phase = wrw_pkg::WRW_PULSE;
          next_st.pulse_cnt = 8'h00;
          next_st.rst_n = 1'b0;
          next_st.halt_grant = 1'b0;
        end
      end
      wrw_pkg::WRW_PULSE: begin
        next_st.pulse_cnt = 8'(st.pulse_cnt + 1'b1);
        if (pulse_end) begin
          // The MCU reset that follows returns the control register to its reset value.
          next_st.phase = wrw_pkg::WRW_RUN;
          next_st.rst_n = 1'b1;
          next_st.pulse_cnt = 8'h00;
          next_st.activate = 1'(`WRW_CTRL_RESET >> `WRW_CTRL_ACT_BIT);
          next_st.count = 7'(`WRW_CTRL_RESET);
        end
      end
      default: begin
        next_st.phase = wrw_pkg::WRW_RUN;
        next_st.rst_n = 1'b1;
      end
    endcase

    // Event bits for the interrupt status.
    if (any_ev) begin
      ev_bits[`WRW_EV_TIMEOUT] = timeout_ev;
      ev_bits[`WRW_EV_SOFT] = soft_ev;
      ev_bits[`WRW_EV_HALT] = halt_ev;
    end

    // APB answer: the read data is captured with pready.
    next_st.pready = setup_done;
    if (setup_done) begin
      next_st.pslverr = (sel == wrw_pkg::WRW_SEL_NONE);
      case (sel)
        wrw_pkg::WRW_SEL_CTRL: rd_byte = {st.activate, st.count};
        wrw_pkg::WRW_SEL_STAT: rd_byte = {7'h00, st.reset_flag && HAS_LVD};
        wrw_pkg::WRW_SEL_ISTAT: rd_byte = {5'h00, st.irq_status};
        wrw_pkg::WRW_SEL_IMASK: rd_byte = {5'h00, st.irq_mask};
        default: rd_byte = 8'h00;
      endcase
      next_st.prdata = {24'h000000, rd_byte};
    end else if (complete) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h00000000;
    end

    // Watchdog reset flag: software clears it, a new watchdog reset wins over the clear.
    if (complete && pwrite && pstrb[0] && (sel == wrw_pkg::WRW_SEL_STAT)
        && !pwdata[`WRW_STAT_FLAG_BIT]) begin
      next_st.reset_flag = 1'b0;
    end
    if (any_ev && HAS_LVD) begin
      next_st.reset_flag = 1'b1;
    end

    // Sticky events: a read clears only the bits it returned; new events win.
    if (complete && !pwrite && (sel == wrw_pkg::WRW_SEL_ISTAT)) begin
      next_st.irq_status = st.irq_status & ~st.prdata[2:0];
    end
    next_st.irq_status = next_st.irq_status | ev_bits;

    // Interrupt mask write.
    if (complete && pwrite && pstrb[0] && (sel == wrw_pkg::WRW_SEL_IMASK)) begin
      next_st.irq_mask = pwdata[2:0];
    end

    // Interrupt level follows the unmasked sticky bits.
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // Other reset sources return the control register to its reset value but keep the flag and events.
    if (!mcu_reset_n) begin
      next_st.phase = wrw_pkg::WRW_RUN;
      next_st.pulse_cnt = 8'h00;
      next_st.rst_n = 1'b1;
      next_st.halt_grant = 1'b0;
      next_st.activate = 1'(`WRW_CTRL_RESET >> `WRW_CTRL_ACT_BIT);
      next_st.count = 7'(`WRW_CTRL_RESET);
    end
  end

  // State register; power reset sets every field to its reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.phase <= wrw_pkg::WRW_RUN;
      st.pulse_cnt <= 8'h00;
      st.activate <= 1'b0;
      st.count <= 7'(`WRW_CTRL_RESET);
      st.reset_flag <= 1'b0;
      st.irq_status <= `WRW_IRQ_RESET;
      st.irq_mask <= `WRW_IRQ_RESET;
      st.hw_opt <= 1'b0;
      st.strap_done <= 1'b0;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.prdata <= 32'h00000000;
      st.irq <= 1'b0;
      st.rst_n <= 1'b1;
      st.halt_grant <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign halt_grant = st.halt_grant;
  assign wdg_reset_n = st.rst_n;
  assign irq = st.irq;

endmodule : wrw_watchdog

// >>> wrw_watchdog_asserts.sv
`timescale 1ns/100ps

module wrw_watchdog_asserts (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Access.
  input wire logic pready, // Ready.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pslverr, // Error.
  input wire logic mcu_reset_n, // System reset.
  input wire logic halt_exec, // Halt request.
  input wire logic halt_grant, // Halt grant.
  input wire logic wdg_reset_n // Reset out.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] lo_len;

  // Counts how long the reset output has stayed low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_len <= 6'h00;
    else if (!wdg_reset_n && mcu_reset_n) lo_len <= lo_len + 6'h01;
    else lo_len <= 6'h00;
  end

  property p_pulse_len;
    $rose(wdg_reset_n) && $past(mcu_reset_n) |-> lo_len == 6'h19;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
  property p_pulse_hold;
    $fell(wdg_reset_n) && mcu_reset_n |-> !wdg_reset_n [*8];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("reset pulse too short");
  property p_halt;
    halt_exec && wdg_reset_n && mcu_reset_n |=> halt_grant == wdg_reset_n;
  endproperty
  a_halt: assert property (p_halt) else $error("halt neither granted nor reset");
  property p_grant;
    halt_grant |-> $past(halt_exec) && wdg_reset_n;
  endproperty
  a_grant: assert property (p_grant) else $error("halt grant without request");
  property p_rdy;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside access phase");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdata;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside transfer");

  c_reset: cover property ($fell(wdg_reset_n));
  c_grant: cover property (halt_grant);
  c_err: cover property (pslverr);
endmodule : wrw_watchdog_asserts

bind wrw_watchdog wrw_watchdog_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .mcu_reset_n(mcu_reset_n), .halt_exec(halt_exec),
  .halt_grant(halt_grant), .wdg_reset_n(wdg_reset_n));

// >>> wrw_tb.sv
`timescale 1ns/100ps
`include "wrw_cfg.svh"

module testbench;
  localparam logic [11:0] A_CTRL = {2'b00, `WRW_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, `WRW_STAT_IDX, 2'b00};
  localparam logic [11:0] A_IST = {2'b00, `WRW_IRQ_STAT_IDX, 2'b00};
  localparam logic [11:0] A_IMSK = {2'b00, `WRW_IRQ_MASK_IDX, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic mcu_reset_n = 1'b1, hw_opt = 1'b0, halt_exec = 1'b0, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [3:0] pstrb = 4'hf;
  wire pready, pslverr, halt_grant, wdg_reset_n, irq;
  wire [31:0] prdata;
  int n_errors = 0, n_checks = 0, n;

  wrw_watchdog #(.PRESCALE(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .mcu_reset_n(mcu_reset_n), .hw_watchdog_option(hw_opt), .halt_exec(halt_exec),
    .halt_grant(halt_grant), .wdg_reset_n(wdg_reset_n), .irq(irq));

  // Free-running clock.
  always #10 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Hold the request until pready is seen high at a rising edge.
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) begin
      chk("pready", 1, 0);
    end
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rdat);
  endtask : rd

  // Waits for the reset output to reach the given level, counting cycles.
  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while (wdg_reset_n !== v && c < 3000);
    if (c >= 3000) begin
      chk("wait reset level", 1, 0);
    end
  endtask : wait_lvl

  // One-cycle halt request, then a settle step so the answer can be read.
  task automatic pulse_halt();
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    #1;
  endtask : pulse_halt

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short.
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end

  // Main test sequence.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, 8'h7f, "ctrl reset");
    rd(A_STAT, 8'h00, "stat reset");
    rd(A_IMSK, 8'h00, "mask reset");
    apb(1'b0, 12'h0a0, 8'h00);
    chk("unmapped err", 1, serr);
    apb(1'b1, A_IMSK, 8'h07);
    pulse_halt();
    chk("grant inactive", 1, halt_grant);
    apb(1'b1, A_CTRL, 8'hc5);
    apb(1'b1, A_CTRL, 8'h45);
    rd(A_CTRL, 8'hc5, "activate sticky");
    apb(1'b1, A_CTRL, 8'hc2);
    wait_lvl(1'b0, n);
    // Count 42h needs two ticks to reach 40h and a third to time out: (2 + 1) * 16 + 1 cycles.
    chk("timeout cycles", 3 * 16 + 1, n);
    wait_lvl(1'b1, n);
    chk("irq level", 1, irq);
    rd(A_CTRL, 8'h7f, "ctrl after reset");
    rd(A_STAT, 8'h01, "flag set");
    rd(A_IST, 8'h01, "timeout event");
    repeat (2) @(posedge pclk);
    #1 chk("irq cleared", 0, irq);
    @(posedge pclk) mcu_reset_n <= 1'b0;
    @(posedge pclk) mcu_reset_n <= 1'b1;
    rd(A_STAT, 8'h01, "flag kept");
    apb(1'b1, A_STAT, 8'h00);
    rd(A_STAT, 8'h00, "flag cleared");
    apb(1'b1, A_CTRL, 8'h80);
    wait_lvl(1'b0, n);
    chk("soft reset", 1, n);
    wait_lvl(1'b1, n);
    rd(A_IST, 8'h02, "soft event");
    apb(1'b1, A_CTRL, 8'hff);
    pulse_halt();
    chk("halt reset", 0, wdg_reset_n);
    wait_lvl(1'b1, n);
    rd(A_IST, 8'h04, "halt event");
    @(posedge pclk) presetn <= 1'b0;
    hw_opt <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_STAT, 8'h00, "flag power reset");
    pulse_halt();
    chk("hardware option", 0, wdg_reset_n);
    wait_lvl(1'b1, n);
    tally_and_finish();
  end
endmodule : testbench
